// ---- ddt_params.svh ----
// Function
// - Loop off: strobe timing reference starts read_latency+additive_latency-1 after read.
// - Cycle counts are nanoseconds over clock period, rounded up.
// - Internal precharge after auto-close waits for row_active_min since activation.
// - Loop off: write_recovery_time at least max of 5 cycles and 15 ns.
// - Write recovery starts write_latency+4, or +2 for fixed chopped bursts.
// - Outputs stay high impedance while device_reset_n is low; drive_en_r drops only on the third edge after the pin falls.
`ifndef DDT_PARAMS_SVH
`define DDT_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and conversion
// ----------------------------------------------------------------
`define CLK_PERIOD_PS     5000
`define NS2CK(ns)         ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define ROW_ACTIVE_MIN_NS 35
`define ROW_ACTIVE_MIN_CK (`NS2CK(`ROW_ACTIVE_MIN_NS))
`define WR_DLLOFF_NS      15
`define WR_DLLOFF_MIN_CK  5
`define WR_DLLOFF_NS_CK   (`NS2CK(`WR_DLLOFF_NS))
`define WR_START_FULL     4
`define WR_START_CHOP     2
`define RD_TO_PRE_CK      4
`define RD_REF_OFFSET     1

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define BANKS             8
`define SCHED_W           64
`define HOLD_W            7
`define AGE_W             8

`endif

// ---- ddt_pkg.sv ----
`default_nettype none
package ddt_pkg;
	typedef enum logic [2:0] {
		DDT_CMD_NOP,
		DDT_CMD_ACT,
		DDT_CMD_RD,
		DDT_CMD_RDA,
		DDT_CMD_WR,
		DDT_CMD_WRA
	} ddt_cmd_t;

	typedef enum logic [1:0] {
		DDT_BM_FULL_EIGHT,
		DDT_BM_CHOP_FIXED,
		DDT_BM_ON_THE_FLY
	} ddt_burst_t;

	typedef enum {
		DDT_BANK_IDLE,
		DDT_BANK_OPEN,
		DDT_BANK_CLOSING
	} ddt_bank_st_t;
endpackage
`default_nettype wire

// ---- ddt_bank_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ddt_params.svh"
interface ddt_bank_if;
	logic                 act;
	logic                 ap_req;
	logic [`HOLD_W-1:0]   ap_hold;
	logic                 pre_fire;
	logic                 ack;
	modport ctrl (output act, output ap_req, output ap_hold,
		output ack, input pre_fire);
	modport bank (input act, input ap_req, input ap_hold,
		input ack, output pre_fire);
endinterface
`default_nettype wire

// ---- ddt_bank_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ddt_params.svh"
module ddt_bank_timer (
	input  wire logic clk,
	input  wire logic rst,
	ddt_bank_if.bank  b
);
	ddt_pkg::ddt_bank_st_t state_r;
	logic [`AGE_W-1:0]  ras_cnt_r;
	logic [`HOLD_W-1:0] hold_cnt_r;
	logic [`AGE_W-1:0]  age_r;

	// ----------------------------------------------------------------
	// Bank state
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ddt_pkg::DDT_BANK_IDLE;
		end else begin
			case (state_r)
				ddt_pkg::DDT_BANK_IDLE: begin
					if (b.act)
						state_r <= ddt_pkg::DDT_BANK_OPEN;
				end
				ddt_pkg::DDT_BANK_OPEN: begin
					if (b.ap_req)
						state_r <= ddt_pkg::DDT_BANK_CLOSING;
				end
				ddt_pkg::DDT_BANK_CLOSING: begin
					if (b.ack)
						state_r <= ddt_pkg::DDT_BANK_IDLE;
				end
				default: state_r <= ddt_pkg::DDT_BANK_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Row-active and recovery hold-off
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst)
			ras_cnt_r <= '0;
		else if (b.act)
			ras_cnt_r <= `AGE_W'(`ROW_ACTIVE_MIN_CK);
		else if (ras_cnt_r != '0)
			ras_cnt_r <= ras_cnt_r - 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst)
			hold_cnt_r <= '0;
		else if (b.ap_req && state_r == ddt_pkg::DDT_BANK_OPEN)
			hold_cnt_r <= b.ap_hold;
		else if (hold_cnt_r != '0)
			hold_cnt_r <= hold_cnt_r - 1'b1;
	end

	// Precharge only once the row has been open long enough
	assign b.pre_fire = (state_r == ddt_pkg::DDT_BANK_CLOSING) &&
		(ras_cnt_r == '0) && (hold_cnt_r == '0);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || b.act)
			age_r <= '0;
		else if (age_r != '1)
			age_r <= age_r + 1'b1;
	end

	property p_ras_hold;
		@(posedge clk) disable iff (rst)
		b.ack |-> (age_r >= `AGE_W'(`ROW_ACTIVE_MIN_CK));
	endproperty
	a_ras_hold: assert property (p_ras_hold)
		else $error("Internal precharge before row active minimum");
endmodule
`default_nettype wire

// ---- ddt_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ddt_params.svh"
module ddt_core (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        device_reset_n,
	input  wire logic        cmd_valid,
	input  wire logic [2:0]  cmd_code,
	input  wire logic [2:0]  cmd_bank,
	input  wire logic        cmd_chop,
	input  wire logic [1:0]  burst_mode,
	input  wire logic        dll_enable,
	input  wire logic [3:0]  read_latency,
	input  wire logic [3:0]  additive_latency,
	input  wire logic [4:0]  write_latency,
	input  wire logic [4:0]  write_recovery,
	output logic             drive_en_r,
	output logic             strobe_ref_start_r,
	output logic             wr_recovery_start_r,
	output logic             precharge_r,
	output logic [2:0]       precharge_bank_r,
	output logic [5:0]       wr_eff_r
);
	logic                 rstn_s1_r;
	logic                 rstn_s2_r;
	logic                 core_rst_r;
	logic [`SCHED_W-1:0]  rd_sched_r;
	logic [`SCHED_W-1:0]  wr_sched_r;
	logic [`BANKS-1:0]    fire_vec;
	logic [`BANKS-1:0]    ack_vec;
	logic                 is_rd;
	logic                 is_wr;
	logic                 is_act;
	logic [5:0]           rd_dly;
	logic [5:0]           wr_dly;
	logic [5:0]           wr_floor;
	logic [`HOLD_W-1:0]   rd_hold;
	logic [`HOLD_W-1:0]   wr_hold;
	ddt_pkg::ddt_cmd_t    cmd;

	// Lowest-numbered bank wins when several are ready together
	function automatic logic [2:0] pick_bank(input logic [`BANKS-1:0] v);
		logic [2:0] r;
		r = '0;
		for (int i = `BANKS - 1; i >= 0; i--) begin
			if (v[i])
				r = 3'(i);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Reset pin
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rstn_s1_r <= 1'b0;
			rstn_s2_r <= 1'b0;
		end else begin
			rstn_s1_r <= device_reset_n;
			rstn_s2_r <= rstn_s1_r;
		end
	end

	// Pin reset clears all internal timing state as well
	always_ff @(posedge clk) begin
		core_rst_r <= rst | ~rstn_s2_r;
	end

	// Output buffers go off three edges after the pin falls, back on three edges after it rises
	always_ff @(posedge clk) begin
		if (rst)
			drive_en_r <= 1'b0;
		else
			drive_en_r <= rstn_s2_r;
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	assign cmd    = cmd_valid ? ddt_pkg::ddt_cmd_t'(cmd_code)
		: ddt_pkg::DDT_CMD_NOP;
	assign is_act = (cmd == ddt_pkg::DDT_CMD_ACT);
	assign is_rd  = (cmd == ddt_pkg::DDT_CMD_RD) ||
		(cmd == ddt_pkg::DDT_CMD_RDA);
	assign is_wr  = (cmd == ddt_pkg::DDT_CMD_WR) ||
		(cmd == ddt_pkg::DDT_CMD_WRA);

	// ----------------------------------------------------------------
	// Write recovery length
	// ----------------------------------------------------------------
	assign wr_floor = (`WR_DLLOFF_MIN_CK > `WR_DLLOFF_NS_CK)
		? 6'(`WR_DLLOFF_MIN_CK) : 6'(`WR_DLLOFF_NS_CK);

	always_ff @(posedge clk) begin
		if (core_rst_r)
			wr_eff_r <= 6'(`WR_DLLOFF_MIN_CK);
		else if (!dll_enable && {1'b0, write_recovery} < wr_floor)
			wr_eff_r <= wr_floor;
		else
			wr_eff_r <= {1'b0, write_recovery};
	end

	// ----------------------------------------------------------------
	// Strobe reference after read with loop off
	// ----------------------------------------------------------------
	assign rd_dly = 6'({2'b00, read_latency} + {2'b00, additive_latency}
		- 6'(`RD_REF_OFFSET));

	// Shift schedule keeps every read in flight, not just one
	always_ff @(posedge clk) begin
		if (core_rst_r)
			rd_sched_r <= '0;
		else if (is_rd && !dll_enable && rd_dly != '0)
			rd_sched_r <= (rd_sched_r >> 1) |
				(`SCHED_W'(1) << (rd_dly - 6'd1));
		else
			rd_sched_r <= rd_sched_r >> 1;
	end

	always_ff @(posedge clk) begin
		if (core_rst_r)
			strobe_ref_start_r <= 1'b0;
		else
			strobe_ref_start_r <= rd_sched_r[0];
	end

	// ----------------------------------------------------------------
	// Write recovery start point
	// ----------------------------------------------------------------
	always_comb begin
		if (burst_mode == 2'(ddt_pkg::DDT_BM_CHOP_FIXED))
			wr_dly = 6'({1'b0, write_latency} + 6'(`WR_START_CHOP));
		else
			wr_dly = 6'({1'b0, write_latency} + 6'(`WR_START_FULL));
	end

	always_ff @(posedge clk) begin
		if (core_rst_r)
			wr_sched_r <= '0;
		else if (is_wr)
			wr_sched_r <= (wr_sched_r >> 1) |
				(`SCHED_W'(1) << (wr_dly - 6'd1));
		else
			wr_sched_r <= wr_sched_r >> 1;
	end

	always_ff @(posedge clk) begin
		if (core_rst_r)
			wr_recovery_start_r <= 1'b0;
		else
			wr_recovery_start_r <= wr_sched_r[0];
	end

	// ----------------------------------------------------------------
	// Auto-close per bank
	// ----------------------------------------------------------------
	assign rd_hold = `HOLD_W'({3'b000, additive_latency} +
		7'(`RD_TO_PRE_CK));
	assign wr_hold = `HOLD_W'({2'b00, wr_dly} + {1'b0, wr_eff_r});

	for (genvar g = 0; g < `BANKS; g++) begin : g_bank
		ddt_bank_if bi ();
		assign bi.act     = is_act && (cmd_bank == 3'(g));
		assign bi.ap_req  = (cmd_bank == 3'(g)) &&
			((cmd == ddt_pkg::DDT_CMD_RDA) ||
			(cmd == ddt_pkg::DDT_CMD_WRA));
		assign bi.ap_hold = (cmd == ddt_pkg::DDT_CMD_WRA)
			? wr_hold : rd_hold;
		assign bi.ack     = ack_vec[g];
		assign fire_vec[g] = bi.pre_fire;
		ddt_bank_timer u_bank (
			.clk (clk),
			.rst (core_rst_r),
			.b   (bi.bank)
		);
	end

	always_comb begin
		ack_vec = '0;
		if (fire_vec != '0)
			ack_vec[pick_bank(fire_vec)] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (core_rst_r) begin
			precharge_r      <= 1'b0;
			precharge_bank_r <= '0;
		end else begin
			precharge_r      <= fire_vec != '0;
			precharge_bank_r <= pick_bank(fire_vec);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [6:0] rd_trk_r;
	logic [6:0] wr_trk_r;

	always_ff @(posedge clk) begin
		if (core_rst_r)
			rd_trk_r <= '0;
		else if (rd_trk_r == '0 && is_rd && !dll_enable && rd_dly != '0)
			rd_trk_r <= {1'b0, rd_dly};
		else if (rd_trk_r != '0)
			rd_trk_r <= rd_trk_r - 7'd1;
	end

	always_ff @(posedge clk) begin
		if (core_rst_r)
			wr_trk_r <= '0;
		else if (wr_trk_r == '0 && is_wr)
			wr_trk_r <= {1'b0, wr_dly};
		else if (wr_trk_r != '0)
			wr_trk_r <= wr_trk_r - 7'd1;
	end

	property p_rd_ref;
		@(posedge clk) disable iff (core_rst_r)
		(rd_trk_r == 7'd1) |=> strobe_ref_start_r;
	endproperty
	a_rd_ref: assert property (p_rd_ref)
		else $error("Strobe reference not at read plus latency");

	property p_wr_start;
		@(posedge clk) disable iff (core_rst_r)
		(wr_trk_r == 7'd1) |=> wr_recovery_start_r;
	endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("Write recovery start at wrong edge");

	property p_wr_dlloff;
		@(posedge clk) disable iff (core_rst_r)
		(!dll_enable && $stable(dll_enable) && $stable(write_recovery))
			|=> (wr_eff_r >= 6'(`WR_DLLOFF_MIN_CK)) &&
			(wr_eff_r >= {1'b0, $past(write_recovery)});
	endproperty
	a_wr_dlloff: assert property (p_wr_dlloff)
		else $error("Write recovery too short with loop off");

	property p_conv;
		@(posedge clk) disable iff (core_rst_r)
		!dll_enable |=> (32'(wr_eff_r) * `CLK_PERIOD_PS >=
			`WR_DLLOFF_NS * 1000);
	endproperty
	a_conv: assert property (p_conv)
		else $error("Write recovery below its nanosecond floor");

	property p_hiz;
		@(posedge clk) disable iff (rst)
		!rstn_s2_r |=> !drive_en_r ##1 !drive_en_r || rstn_s2_r;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("Outputs driven during device reset");

	property p_pre_ok;
		@(posedge clk) disable iff (core_rst_r)
		precharge_r |=> !(precharge_r &&
			precharge_bank_r == $past(precharge_bank_r));
	endproperty
	a_pre_ok: assert property (p_pre_ok)
		else $error("Precharge without ready bank");

	c_rd_off: cover property (@(posedge clk) disable iff (core_rst_r)
		is_rd && !dll_enable ##[1:40] strobe_ref_start_r);
	c_wr_chop: cover property (@(posedge clk) disable iff (core_rst_r)
		is_wr && burst_mode == 2'(ddt_pkg::DDT_BM_CHOP_FIXED)
		##[1:40] wr_recovery_start_r);
	c_pre: cover property (@(posedge clk) disable iff (core_rst_r)
		precharge_r);
endmodule
`default_nettype wire

// ---- ddt_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddt_ctrl_model #(
	parameter int CLK_PS = 5000,
	parameter bit HOT    = 1'b0
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       dll_enable,
	input  wire logic [3:0] read_latency,
	input  wire logic [3:0] additive_latency,
	output var  logic       cmd_valid,
	output var  logic [2:0] cmd_code,
	output var  logic [2:0] cmd_bank,
	output var  logic       cmd_chop
);
	// ----------------------------------------
	// Exit delay, cycles rounded up
	// ----------------------------------------
	localparam int NS_CK = (24000 + CLK_PS - 1) / CLK_PS;
	localparam int EXIT_CK = (NS_CK > 10) ? NS_CK : 10;
	logic [8:0] cfg_r;
	logic [4:0] gap_r;

	// ----------------------------------------
	// Refresh cadence; rows are not modelled, refresh is sent to bank 0 only
	// ----------------------------------------
	localparam int REFI_CK = 7812500 / CLK_PS;
	localparam int REF_CK  = HOT ? REFI_CK / 2 : REFI_CK;
	localparam int WIN9_CK = 70300000 / CLK_PS;
	localparam int PDEN_CK = 2;
	localparam bit SLOW_CK = CLK_PS > 40000;

	initial begin
		cmd_valid = 1'b0;
		cmd_code = 3'h0;
		cmd_bank = 3'h0;
		cmd_chop = 1'b0;
	end

	// Any read or additive latency or loop change restarts the wait
	always_ff @(posedge clk) begin
		cfg_r <= {dll_enable, read_latency, additive_latency};
		if (rst)
			gap_r <= 5'h00;
		else if (cfg_r != {dll_enable, read_latency, additive_latency})
			gap_r <= 5'(EXIT_CK);
		else if (gap_r != 5'h00)
			gap_r <= gap_r - 5'h01;
	end

	// ----------------------------------------
	// Command tasks, driven off the falling edge
	// ----------------------------------------
	task automatic issue(input logic [2:0] code, input logic [2:0] bank,
		input logic chop);
		@(negedge clk);
		// Drop the lines while held off so the last command is not repeated
		while ((code == 3'h2 || code == 3'h3) && gap_r != 5'h00) begin
			cmd_valid = 1'b0;
			@(negedge clk);
		end
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_bank = bank;
		cmd_chop = chop;
	endtask

	// Released lines do not keep their last value
	task automatic idle();
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code = cmd_code ^ 3'h7;
		cmd_bank = ~cmd_bank;
		cmd_chop = ~cmd_chop;
	endtask

	// Refresh code is reserved on this port; the timing block ignores it
	task automatic refresh();
		issue(3'h6, 3'h0, 1'b0);
		idle();
		if (SLOW_CK)
			idle();
		repeat (dll_enable ? PDEN_CK : EXIT_CK) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ---- ddt_testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define DDT_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	failures++; $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp); \
	end end
module testbench;
	logic       clk, rst, device_reset_n, cmd_valid, cmd_chop, dll_enable;
	logic [2:0] cmd_code, cmd_bank, precharge_bank_r;
	logic [1:0] burst_mode;
	logic [3:0] read_latency, additive_latency;
	logic [4:0] write_latency, write_recovery;
	logic       drive_en_r, strobe_ref_start_r;
	logic       wr_recovery_start_r, precharge_r;
	logic [5:0] wr_eff_r;
	int         failures, comparisons, f, c;
	logic [2:0] pb;

	ddt_core u_dut (.clk(clk), .rst(rst), .device_reset_n(device_reset_n),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
		.cmd_chop(cmd_chop), .burst_mode(burst_mode),
		.dll_enable(dll_enable), .read_latency(read_latency),
		.additive_latency(additive_latency), .write_latency(write_latency),
		.write_recovery(write_recovery), .drive_en_r(drive_en_r),
		.strobe_ref_start_r(strobe_ref_start_r),
		.wr_recovery_start_r(wr_recovery_start_r),
		.precharge_r(precharge_r), .precharge_bank_r(precharge_bank_r),
		.wr_eff_r(wr_eff_r));

	ddt_ctrl_model u_model (.clk(clk), .rst(rst), .dll_enable(dll_enable),
		.read_latency(read_latency), .additive_latency(additive_latency),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
		.cmd_chop(cmd_chop));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Counts edges after a take; 0 selects strobe, 1 write, 2 precharge
	task automatic watch(input int sel, input int lim, output int first,
		output int cnt, output logic [2:0] bank);
		logic hit;
		first = 0;
		cnt = 0;
		bank = 3'h0;
		for (int n = 1; n <= lim; n++) begin
			@(posedge clk);
			#1;
			hit = (sel == 0) ? strobe_ref_start_r :
				(sel == 1) ? wr_recovery_start_r : precharge_r;
			if (hit === 1'b1) begin
				cnt++;
				if (first == 0) begin
					first = n;
					bank = precharge_bank_r;
				end
			end
		end
	endtask

	task automatic t_pin();
		@(negedge clk);
		device_reset_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 `DDT_CHK(drive_en_r, 1'b1)
		@(posedge clk);
		#1 `DDT_CHK(drive_en_r, 1'b0)
		@(negedge clk);
		device_reset_n = 1'b1;
		repeat (2) @(posedge clk);
		#1 `DDT_CHK(drive_en_r, 1'b0)
		@(posedge clk);
		#1 `DDT_CHK(drive_en_r, 1'b1)
		repeat (3) @(negedge clk);
		$display("test pin reset done");
	endtask

	task automatic t_read();
		int rl[3] = '{5, 6, 11};
		int al[3] = '{0, 2, 1};
		int d;
		dll_enable = 1'b0;
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			read_latency = 4'(rl[i]);
			additive_latency = 4'(al[i]);
			d = rl[i] + al[i] - 1;
			u_model.issue(3'h2, 3'h0, 1'b0);
			u_model.idle();
			watch(0, d + 3, f, c, pb);
			`DDT_CHK(f, d)
			`DDT_CHK(c, 1)
		end
		// Back to back: second take is one edge later
		u_model.issue(3'h2, 3'h0, 1'b0);
		u_model.issue(3'h2, 3'h0, 1'b0);
		u_model.idle();
		watch(0, d + 3, f, c, pb);
		`DDT_CHK(f, d - 1)
		`DDT_CHK(c, 2)
		@(negedge clk);
		dll_enable = 1'b1;
		u_model.issue(3'h2, 3'h0, 1'b0);
		u_model.idle();
		watch(0, 20, f, c, pb);
		`DDT_CHK(c, 0)
		$display("test read reference done");
	endtask

	task automatic t_write();
		int wl[3] = '{5, 7, 6};
		int st[3] = '{4, 2, 4};
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			burst_mode = 2'(i);
			write_latency = 5'(wl[i]);
			u_model.issue(3'h4, 3'h0, i == 2);
			u_model.idle();
			watch(1, wl[i] + 7, f, c, pb);
			`DDT_CHK(f, wl[i] + st[i])
			`DDT_CHK(c, 1)
		end
		@(negedge clk);
		burst_mode = 2'h0;
		write_latency = 5'h05;
		$display("test write start done");
	endtask

	task automatic t_wr_eff();
		logic       dl[3] = '{1'b0, 1'b0, 1'b1};
		logic [4:0] wr[3] = '{5'h03, 5'h08, 5'h03};
		logic [5:0] ex[3] = '{6'h05, 6'h08, 6'h03};
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			dll_enable = dl[i];
			write_recovery = wr[i];
			repeat (2) @(posedge clk);
			#1 `DDT_CHK(wr_eff_r, ex[i])
		end
		@(negedge clk);
		write_recovery = 5'h06;
		$display("test recovery floor done");
	endtask

	task automatic t_close();
		@(negedge clk);
		additive_latency = 4'h0;
		// Let the latency-change hold-off run out before ACT
		repeat (12) @(negedge clk);
		u_model.issue(3'h1, 3'h3, 1'b0);
		u_model.issue(3'h3, 3'h3, 1'b0);
		u_model.idle();
		watch(2, 12, f, c, pb);
		`DDT_CHK(f, 7)
		`DDT_CHK(pb, 3'h3)
		`DDT_CHK(c, 1)
		// Bank is closed now, so nothing may follow
		u_model.issue(3'h3, 3'h3, 1'b0);
		u_model.idle();
		watch(2, 20, f, c, pb);
		`DDT_CHK(c, 0)
		u_model.issue(3'h1, 3'h5, 1'b0);
		u_model.idle();
		repeat (10) @(negedge clk);
		u_model.issue(3'h5, 3'h5, 1'b0);
		u_model.idle();
		watch(2, 22, f, c, pb);
		`DDT_CHK(f, 5 + 4 + 6 + 1)
		`DDT_CHK(pb, 3'h5)
		u_model.refresh();
		watch(2, 6, f, c, pb);
		`DDT_CHK(c, 0)
		$display("test autoclose done");
	endtask

	task automatic end_sim();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#100000;
		failures++;
		end_sim();
	end

	initial begin
		failures = 0;
		comparisons = 0;
		rst = 1'b1;
		device_reset_n = 1'b1;
		dll_enable = 1'b1;
		burst_mode = 2'h0;
		read_latency = 4'h5;
		additive_latency = 4'h0;
		write_latency = 5'h05;
		write_recovery = 5'h06;
		repeat (5) @(posedge clk);
		#1 `DDT_CHK(drive_en_r, 1'b0)
		@(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		t_pin();
		t_read();
		t_write();
		t_wr_eff();
		t_close();
		end_sim();
	end
endmodule
`default_nettype wire
